// [pkg/pit_pkg.sv]
package pit_pkg;

  // Host address of the control-word register
  localparam logic [1:0] ADDR_CTL  = 2'h3;
  // Counter pick code that selects nothing
  localparam logic [1:0] PICK_NONE = 2'h3;

  // Byte access codes
  localparam logic [1:0] ACC_LATCH = 2'h0;
  localparam logic [1:0] ACC_LO    = 2'h1;
  localparam logic [1:0] ACC_HI    = 2'h2;
  localparam logic [1:0] ACC_BOTH  = 2'h3;

  // Control word field positions
  localparam int unsigned CW_PICK_HI = 7;
  localparam int unsigned CW_PICK_LO = 6;
  localparam int unsigned CW_ACC_HI  = 5;
  localparam int unsigned CW_ACC_LO  = 4;
  localparam int unsigned CW_MODE_HI = 3;
  localparam int unsigned CW_MODE_LO = 1;
  localparam int unsigned CW_BCD     = 0;

  // Reset and arithmetic values
  localparam logic [15:0] CNT_RST   = 16'h0000;
  localparam logic        OUT_RST   = 1'h1;
  localparam logic [3:0]  BCD_NINE  = 4'h9;
  localparam logic [7:0]  BYTE_ZERO = 8'h00;

  // Operating modes, one-hot
  typedef enum logic [5:0] {
    MODE0 = 6'h01,
    MODE1 = 6'h02,
    MODE2 = 6'h04,
    MODE3 = 6'h08,
    MODE4 = 6'h10,
    MODE5 = 6'h20
  } pit_mode_e;

  // Pin inputs as sampled together
  typedef struct packed {
    logic [2:0] gate;
    logic [2:0] tclk;
    logic [7:0] data;
    logic       addr_sel_hi;
    logic       addr_sel_lo;
    logic       wr_n;
    logic       rd_n;
    logic       cs_n;
  } pit_pin_s;

  localparam pit_pin_s PIN_IDLE = '{gate: 3'h0, tclk: 3'h0, data: 8'h00,
                                    addr_sel_hi: 1'h0, addr_sel_lo: 1'h0,
                                    wr_n: 1'h1, rd_n: 1'h1, cs_n: 1'h1};

endpackage

// [pkg/pit_cnt_if.sv]
`timescale 1ns/10ps
`default_nettype none

// Link between the host side logic and one counter
interface pit_cnt_if;
  logic       ce;
  logic       gate;
  logic       wr_ctl;
  logic       wr_dat;
  logic       rd_adv;
  logic [7:0] din;
  logic [7:0] dout;
  logic       out;

  modport host (output ce, gate, wr_ctl, wr_dat, rd_adv, din, input dout, out);
  modport cnt  (input ce, gate, wr_ctl, wr_dat, rd_adv, din, output dout, out);
endinterface

`default_nettype wire

// [logic/pit_counter.sv]
`timescale 1ns/10ps
`default_nettype none

module pit_counter (
  input  wire logic clk_in,
  input  wire logic rst_in,
  pit_cnt_if.cnt    bus
);

  typedef struct packed {
    pit_pkg::pit_mode_e mode;
    logic               bcd;
    logic [1:0]         acc;
    logic               cfg;
    logic               run;
    logic               armed;
    logic [15:0]        cnt;
    logic [15:0]        init;
    logic [15:0]        hold;
    logic               held;
    logic               wr_hi;
    logic               rd_hi;
    logic               out;
    logic               gate_d;
    logic               trig;
  } pit_cnt_s;

  pit_cnt_s r;
  pit_cnt_s n;

  // One step down, binary or four decades
  function automatic logic [15:0] dec(input logic [15:0] x, input logic bcd);
    logic [15:0] y;
    logic        bw;
    y  = x;
    bw = 1'b1;
    if (!bcd)
    begin
      y = x - 16'h0001;
    end
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (bw)
        begin
          if (x[i*4 +: 4] == 4'h0)
          begin
            y[i*4 +: 4] = pit_pkg::BCD_NINE;
          end
          else
          begin
            y[i*4 +: 4] = x[i*4 +: 4] - 4'h1;
            bw          = 1'b0;
          end
        end
      end
    end
    return y;
  endfunction

  // Mode field to mode, x1x meaning 2 or 3
  function automatic pit_pkg::pit_mode_e mode_of(input logic [2:0] m);
    pit_pkg::pit_mode_e e;
    case (m)
      3'h0:    e = pit_pkg::MODE0;
      3'h1:    e = pit_pkg::MODE1;
      3'h4:    e = pit_pkg::MODE4;
      3'h5:    e = pit_pkg::MODE5;
      3'h2,
      3'h6:    e = pit_pkg::MODE2;
      default: e = pit_pkg::MODE3;
    endcase
    return e;
  endfunction

  logic [15:0] down;
  logic [15:0] src;
  logic [15:0] sq_step;
  logic        load;
  logic [15:0] new_init;
  logic        latch_now;

  // Read source and byte choice
  always_comb
  begin
    src = r.held ? r.hold : r.cnt;
    if (r.acc == pit_pkg::ACC_HI || (r.acc == pit_pkg::ACC_BOTH && r.rd_hi))
      bus.dout = src[15:8];
    else
      bus.dout = src[7:0];
  end

  assign bus.out = r.out;
  assign down    = dec(r.cnt, r.bcd);
  assign sq_step = r.cnt[0] ? (r.out ? 16'h0001 : 16'h0003) : 16'h0002;

  // Next state: counting, then host writes and reads
  always_comb
  begin
    n        = r;
    load     = 1'b0;
    new_init = r.init;
    latch_now = bus.wr_ctl
                && (bus.din[pit_pkg::CW_ACC_HI:pit_pkg::CW_ACC_LO] == pit_pkg::ACC_LATCH);
    n.gate_d = bus.gate;
    if (bus.gate && !r.gate_d && r.run)
      n.trig = 1'b1;
    if (bus.ce && r.cfg && r.run)
    begin
      case (r.mode)
        pit_pkg::MODE0:
        begin
          if (bus.gate)
          begin
            n.cnt = down;
            if (down == 16'h0000)
              n.out = 1'b1;
          end
        end
        pit_pkg::MODE1,
        pit_pkg::MODE5:
        begin
          if (r.mode == pit_pkg::MODE5)
            n.out = 1'b1;
          if (r.trig)
          begin
            n.trig  = 1'b0;
            n.armed = 1'b1;
            n.cnt   = r.init;
            if (r.mode == pit_pkg::MODE1)
              n.out = 1'b0;
          end
          else if (r.armed)
          begin
            n.cnt = down;
            if (down == 16'h0000)
            begin
              n.armed = 1'b0;
              n.out   = (r.mode == pit_pkg::MODE1);
            end
          end
        end
        pit_pkg::MODE2:
        begin
          n.out = 1'b1;
          if (!bus.gate)
            n.cnt = r.init;
          else if (r.cnt == 16'h0001)
          begin
            n.out = 1'b0;
            n.cnt = r.init;
          end
          else
            n.cnt = down;
        end
        pit_pkg::MODE3:
        begin
          if (!bus.gate)
          begin
            n.out = 1'b1;
            n.cnt = r.init;
          end
          else if (r.cnt != 16'h0000 && r.cnt <= sq_step)
          begin
            n.out = !r.out;
            n.cnt = r.init;
          end
          else
            n.cnt = r.cnt - sq_step;
        end
        pit_pkg::MODE4:
        begin
          n.out = 1'b1;
          if (bus.gate && r.armed)
          begin
            n.cnt = down;
            if (down == 16'h0000)
            begin
              n.out   = 1'b0;
              n.armed = 1'b0;
            end
          end
        end
        default: n = r;
      endcase
    end
    // Control word aimed at this counter
    if (bus.wr_ctl)
    begin
      if (latch_now)
      begin
        if (!r.held)
        begin
          n.hold = r.cnt;
          n.held = 1'b1;
        end
      end
      else
      begin
        n.mode  = mode_of(bus.din[pit_pkg::CW_MODE_HI:pit_pkg::CW_MODE_LO]);
        n.bcd   = bus.din[pit_pkg::CW_BCD];
        n.acc   = bus.din[pit_pkg::CW_ACC_HI:pit_pkg::CW_ACC_LO];
        n.cfg   = 1'b1;
        n.run   = 1'b0;
        n.armed = 1'b0;
        n.trig  = 1'b0;
        n.held  = 1'b0;
        n.wr_hi = 1'b0;
        n.rd_hi = 1'b0;
        n.out   = (mode_of(bus.din[pit_pkg::CW_MODE_HI:pit_pkg::CW_MODE_LO])
                   != pit_pkg::MODE0);
      end
    end
    // Count byte from the host
    if (bus.wr_dat && r.cfg)
    begin
      case (r.acc)
        pit_pkg::ACC_LO:
        begin
          new_init = {pit_pkg::BYTE_ZERO, bus.din};
          load     = 1'b1;
        end
        pit_pkg::ACC_HI:
        begin
          new_init = {bus.din, pit_pkg::BYTE_ZERO};
          load     = 1'b1;
        end
        pit_pkg::ACC_BOTH:
        begin
          if (!r.wr_hi)
          begin
            new_init[7:0] = bus.din;
            n.wr_hi       = 1'b1;
            if (r.mode == pit_pkg::MODE0)
              n.run = 1'b0;
          end
          else
          begin
            new_init[15:8] = bus.din;
            n.wr_hi        = 1'b0;
            load           = 1'b1;
          end
        end
        default: load = 1'b0;
      endcase
      n.init = new_init;
    end
    if (load)
    begin
      n.run   = 1'b1;
      n.armed = 1'b1;
      if (r.mode != pit_pkg::MODE1 && r.mode != pit_pkg::MODE5)
        n.cnt = new_init;
      else
        n.armed = r.armed && r.run;
      if (r.mode == pit_pkg::MODE0)
        n.out = 1'b0;
    end
    // Host finished reading one byte
    if (bus.rd_adv)
    begin
      if (r.acc == pit_pkg::ACC_BOTH && !r.rd_hi)
        n.rd_hi = 1'b1;
      else
      begin
        n.rd_hi = 1'b0;
        // A latch in the same cycle as the release wins and takes a fresh copy
        n.held  = latch_now;
        n.hold  = latch_now ? r.cnt : n.hold;
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      r      <= '0;
      r.mode <= pit_pkg::MODE0;
      r.cnt  <= pit_pkg::CNT_RST;
      r.out  <= pit_pkg::OUT_RST;
    end
    else
      r <= n;
  end

endmodule // pit_counter

`default_nettype wire

// [logic/pit_top.sv]
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Three 16-bit presettable down counters, each with clock, gate and output pins.
// - The counters are identical separate instances and never affect each other.
// - A counter steps down on its clock's falling edge, binary or decimal; mode 3 always steps in binary.
// - Six modes per counter: timer, one-shot, two rate modes, two strobes.
// - All control, count and read data pass one 8-bit three-state port.
// - Chip select high ignores strobes and leaves the data port undriven.
// - Chip select only gates host access, never counting or outputs.
// - Chip select and read low drive the addressed counter's count out.
// - Chip select and write low store the byte into the addressed target.
// - Two address inputs pick one of three counters or the control word.
// - The control word is write-only and never read back.
// - The control word sets mode and decimal choice for its picked counter.
// - Counts are readable anytime; a latch command freezes a stable copy.
// - Address 11 is the control word; 00, 01, 10 are counters.
// - Control word: counter pick, byte access, mode, decimal bit, top down.
// - Access 01 low only, 10 high only, 11 low then high, 00 latches.
// - Initial zero gives the longest count; decimal counts up to 9999.
module pit_top (
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic       CS_N_IN,
  input  wire logic       RD_N_IN,
  input  wire logic       WR_N_IN,
  input  wire logic       ADDR_SEL_LO_IN,
  input  wire logic       ADDR_SEL_HI_IN,
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE_N_OUT,
  input  wire logic [2:0] TMR_CLK_IN,
  input  wire logic [2:0] TMR_GATE_IN,
  output logic      [2:0] TMR_OUT_OUT
);

  localparam int unsigned PW = $bits(pit_pkg::pit_pin_s);

  typedef struct packed {
    logic [PW-1:0]     s1;
    logic [PW-1:0]     s2;
    logic [PW-1:0]     s3;
    pit_pkg::pit_pin_s f;
    logic [2:0]        ce;
    logic [2:0]        wr_ctl;
    logic [2:0]        wr_dat;
    logic [2:0]        rd_adv;
    logic [7:0]        din;
    logic [7:0]        dout;
    logic              oe_n;
  } pit_top_s;

  pit_top_s          r;
  pit_top_s          n;
  pit_pkg::pit_pin_s pins;
  logic [7:0]        cdout [3];
  logic [1:0]        addr_old;
  logic [1:0]        addr_new;
  logic [1:0]        pick;
  logic              wr_end;
  logic              rd_end;
  logic              rd_act;

  assign pins = '{gate: TMR_GATE_IN, tclk: TMR_CLK_IN, data: DATA_IN,
                  addr_sel_hi: ADDR_SEL_HI_IN, addr_sel_lo: ADDR_SEL_LO_IN,
                  wr_n: WR_N_IN, rd_n: RD_N_IN, cs_n: CS_N_IN};

  pit_cnt_if cif [3] ();

  // Three counter instances, each on its own pins
  for (genvar i = 0; i < 3; i++)
  begin : g_cnt
    assign cif[i].ce     = r.ce[i];
    assign cif[i].gate   = r.f.gate[i];
    assign cif[i].wr_ctl = r.wr_ctl[i];
    assign cif[i].wr_dat = r.wr_dat[i];
    assign cif[i].rd_adv = r.rd_adv[i];
    assign cif[i].din    = r.din;
    assign cdout[i]      = cif[i].dout;
    assign TMR_OUT_OUT[i] = cif[i].out;

    pit_counter pit_counter_i (
      .clk_in (CLK_IN),
      .rst_in (RST_IN),
      .bus    (cif[i])
    );
  end

  assign DATA_OUT      = r.dout;
  assign DATA_OE_N_OUT = r.oe_n;

  // Pin sampling, strobe edges and access decode
  always_comb
  begin
    n        = r;
    n.s1     = pins;
    n.s2     = r.s1;
    n.s3     = r.s2;
    // A bit changes only once the second and third stages agree
    n.f      = pit_pkg::pit_pin_s'((r.s2 & r.s3) | (r.f & (r.s2 ^ r.s3)));
    n.ce     = r.f.tclk & ~n.f.tclk;
    n.wr_ctl = 3'h0;
    n.wr_dat = 3'h0;
    n.rd_adv = 3'h0;
    addr_old = {r.f.addr_sel_hi, r.f.addr_sel_lo};
    addr_new = {n.f.addr_sel_hi, n.f.addr_sel_lo};
    pick     = r.f.data[pit_pkg::CW_PICK_HI:pit_pkg::CW_PICK_LO];
    wr_end   = !r.f.cs_n && !r.f.wr_n && n.f.wr_n;
    rd_end   = !r.f.cs_n && !r.f.rd_n && n.f.rd_n;
    rd_act   = !n.f.cs_n && !n.f.rd_n;
    if (wr_end)
    begin
      n.din = r.f.data;
      if (addr_old == pit_pkg::ADDR_CTL)
      begin
        if (pick != pit_pkg::PICK_NONE)
          n.wr_ctl[pick] = 1'b1;
      end
      else
        n.wr_dat[addr_old] = 1'b1;
    end
    if (rd_end && addr_old != pit_pkg::ADDR_CTL)
      n.rd_adv[addr_old] = 1'b1;
    n.oe_n = !rd_act;
    case (addr_new)
      2'h0:    n.dout = cdout[0];
      2'h1:    n.dout = cdout[1];
      2'h2:    n.dout = cdout[2];
      default: n.dout = pit_pkg::BYTE_ZERO;
    endcase
  end

  // State register
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      r      <= '0;
      r.s1   <= pit_pkg::PIN_IDLE;
      r.s2   <= pit_pkg::PIN_IDLE;
      r.s3   <= pit_pkg::PIN_IDLE;
      r.f    <= pit_pkg::PIN_IDLE;
      r.oe_n <= 1'b1;
    end
    else
      r <= n;
  end

endmodule // pit_top

`default_nettype wire

// [dv/pit_top_chk.sv]
`timescale 1ns/10ps
`default_nettype none

module pit_top_chk (
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic       CS_N_IN,
  input  wire logic       RD_N_IN,
  input  wire logic       WR_N_IN,
  input  wire logic       ADDR_SEL_LO_IN,
  input  wire logic       ADDR_SEL_HI_IN,
  input  wire logic [7:0] DATA_OUT,
  input  wire logic       DATA_OE_N_OUT,
  input  wire logic [2:0] TMR_CLK_IN,
  input  wire logic [2:0] TMR_GATE_IN,
  input  wire logic [2:0] TMR_OUT_OUT
);
  logic wrote_r;

  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);

  // Remembers any selected write since reset
  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
      wrote_r <= 1'b0;
    else if (!CS_N_IN && !WR_N_IN)
      wrote_r <= 1'b1;
  end

  // Host port relations; pin filter needs up to 5 cycles
  reset_vals_a: assert property ($fell(RST_IN) |->
    DATA_OE_N_OUT && DATA_OUT == 8'h00 && TMR_OUT_OUT == 3'h7) else $error("Bad reset state");
  cs_float_a: assert property (CS_N_IN [*7] |-> DATA_OE_N_OUT)
    else $error("Bus driven while deselected");
  rd_drive_a: assert property ((!CS_N_IN && !RD_N_IN && WR_N_IN) [*5] |-> !DATA_OE_N_OUT)
    else $error("Read not driven");
  idle_float_a: assert property (RD_N_IN [*7] |-> DATA_OE_N_OUT)
    else $error("Bus driven without read");
  wr_float_a: assert property (!WR_N_IN [*5] |-> DATA_OE_N_OUT)
    else $error("Bus driven during write");
  ctl_zero_a: assert property ((ADDR_SEL_HI_IN && ADDR_SEL_LO_IN) [*7] ##0 !DATA_OE_N_OUT
    |-> DATA_OUT == 8'h00) else $error("Control word read back");
  out_quiet_a: assert property ((WR_N_IN && $stable(TMR_CLK_IN) && $stable(TMR_GATE_IN)) [*8]
    |=> $stable(TMR_OUT_OUT)) else $error("Output moved without cause");
  unprog_idle_a: assert property (!wrote_r |-> TMR_OUT_OUT == 3'h7)
    else $error("Unprogrammed counter active");

  // Main scenarios reached
  cover property (!DATA_OE_N_OUT);
  cover property ($fell(TMR_OUT_OUT[1]));
  cover property (CS_N_IN && !WR_N_IN);
endmodule // pit_top_chk

bind pit_top pit_top_chk pit_top_chk_i (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CS_N_IN(CS_N_IN),
  .RD_N_IN(RD_N_IN), .WR_N_IN(WR_N_IN), .ADDR_SEL_LO_IN(ADDR_SEL_LO_IN),
  .ADDR_SEL_HI_IN(ADDR_SEL_HI_IN), .DATA_OUT(DATA_OUT), .DATA_OE_N_OUT(DATA_OE_N_OUT),
  .TMR_CLK_IN(TMR_CLK_IN), .TMR_GATE_IN(TMR_GATE_IN), .TMR_OUT_OUT(TMR_OUT_OUT));

`default_nettype wire

// [dv/pit_host_bfm.sv]
`timescale 1ns/10ps
`default_nettype none

module pit_host_bfm (
  input  wire logic       clk_in,
  input  wire logic [7:0] bus_in,
  input  wire logic       oe_n_in,
  output logic            cs_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic      [1:0] addr_out,
  output logic      [7:0] dq_out,
  output logic            dq_en_out
);
  // Idle bus at time zero
  initial
  begin
    cs_n_out = 1'b1;
    rd_n_out = 1'b1;
    wr_n_out = 1'b1;
    addr_out = 2'h0;
    dq_out = 8'h00;
    dq_en_out = 1'b0;
  end

  // Write cycle; strobe and hold kept long enough for the pin filter
  task automatic wr(input logic cs, input logic [1:0] a, input logic [7:0] d);
    cs_n_out <= cs;
    addr_out <= a;
    dq_out <= d;
    dq_en_out <= 1'b1;
    wr_n_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    wr_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    cs_n_out <= 1'b1;
    dq_en_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask

  // Read cycle; waits for the drive enable under a bound
  task automatic rd(input logic [1:0] a, output logic [7:0] d, output logic to);
    int n;
    cs_n_out <= 1'b0;
    addr_out <= a;
    rd_n_out <= 1'b0;
    for (n = 0; n < 12 && oe_n_in !== 1'b0; n++)
      @(posedge clk_in);
    to = (oe_n_in !== 1'b0);
    @(posedge clk_in);
    d = bus_in;
    rd_n_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (4) @(posedge clk_in);
  endtask
endmodule // pit_host_bfm

`default_nettype wire

// [dv/pit_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("Error t=%0t got=%h exp=%h", $time, (a), (b)); end end

module pit_top_tb;
  logic       clk;
  logic       rst;
  logic [2:0] tclk;
  logic [2:0] gate;
  logic [2:0] tout;
  logic [7:0] dout;
  logic [7:0] bus;
  logic [7:0] dq;
  logic [7:0] cyc;
  logic [1:0] addr;
  logic       oe_n;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       dq_en;
  int         mismatches;
  int         check_count;

  // Clock and a changing pattern for the released bus
  initial clk = 1'b0;
  always #20 clk = ~clk;
  always_ff @(posedge clk)
  begin
    if (rst)
      cyc <= 8'h00;
    else
      cyc <= cyc + 8'h01;
  end
  assign bus = !oe_n ? dout : dq_en ? dq : cyc;

  pit_top pit_top_i (.CLK_IN(clk), .RST_IN(rst), .CS_N_IN(cs_n), .RD_N_IN(rd_n),
    .WR_N_IN(wr_n), .ADDR_SEL_LO_IN(addr[0]), .ADDR_SEL_HI_IN(addr[1]), .DATA_IN(bus),
    .DATA_OUT(dout), .DATA_OE_N_OUT(oe_n), .TMR_CLK_IN(tclk), .TMR_GATE_IN(gate),
    .TMR_OUT_OUT(tout));
  pit_host_bfm pit_host_bfm_i (.clk_in(clk), .bus_in(bus), .oe_n_in(oe_n), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .addr_out(addr), .dq_out(dq), .dq_en_out(dq_en));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic w(input logic [1:0] a, input logic [7:0] d);
    pit_host_bfm_i.wr(1'b0, a, d);
  endtask

  // Read and compare; a missing drive ends the run
  task automatic r(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       to;
    pit_host_bfm_i.rd(a, d, to);
    if (to)
    begin
      mismatches++;
      report_and_stop();
    end
    else
      `CHK(d, e)
  endtask

  // Falling edges on one counter clock pin
  task automatic tick(input int k, input int n);
    repeat (n)
    begin
      tclk[k] <= 1'b0;
      repeat (5) @(posedge clk);
      tclk[k] <= 1'b1;
      repeat (5) @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    tclk = 3'h7;
    gate = 3'h7;
    mismatches = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    tick(0, 2);
    tick(2, 2);
    `CHK(tout, 3'h7)
    w(2'h3, 8'h70);
    `CHK(tout, 3'h5)
    w(2'h1, 8'h05);
    w(2'h1, 8'h00);
    tick(1, 2);
    w(2'h3, 8'h40);
    tick(1, 1);
    r(2'h1, 8'h03);
    r(2'h1, 8'h00);
    r(2'h1, 8'h02);
    r(2'h1, 8'h00);
    tick(1, 1);
    `CHK(tout, 3'h5)
    tick(1, 1);
    `CHK(tout, 3'h7)
    w(2'h3, 8'h91);
    w(2'h2, 8'h10);
    tick(2, 1);
    r(2'h2, 8'h09);
    pit_host_bfm_i.wr(1'b1, 2'h2, 8'h55);
    r(2'h2, 8'h09);
    w(2'h3, 8'h20);
    w(2'h0, 8'h01);
    r(2'h0, 8'h01);
    tick(0, 1);
    r(2'h0, 8'h00);
    w(2'h3, 8'h10);
    w(2'h0, 8'h00);
    tick(0, 1);
    r(2'h0, 8'hFF);
    r(2'h3, 8'h00);
    w(2'h3, 8'hF0);
    `CHK(tout, 3'h2)
    for (int m = 0; m < 6; m++)
    begin
      w(2'h3, {4'h9, m[2:0], 1'b0});
      `CHK(tout[2], (m != 0))
    end
    // Rate mode: the low pulse comes on the clock that finds the count at one
    w(2'h3, 8'h14);
    w(2'h0, 8'h03);
    tick(0, 3);
    `CHK(tout[0], 1'b0)
    tick(0, 1);
    `CHK(tout[0], 1'b1)
    w(2'h3, 8'h98);
    w(2'h2, 8'h02);
    tick(2, 1);
    `CHK(tout[2], 1'b1)
    tick(2, 1);
    `CHK(tout[2], 1'b0)
    // One-shot on counter 1, started by a gate rise
    w(2'h3, 8'h52);
    w(2'h1, 8'h02);
    gate[1] <= 1'b0;
    repeat (6) @(posedge clk);
    gate[1] <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(tout[1], 1'b1)
    tick(1, 2);
    `CHK(tout[1], 1'b0)
    tick(1, 1);
    `CHK(tout[1], 1'b1)
    report_and_stop();
  end
endmodule // pit_top_tb

`default_nettype wire
